/* src/cotp_pkg.sv */
package cotp_pkg;
    // Register word indices; the byte address is four times the index
    localparam logic [7:0] COTP_OFS_BANK0 = 8'hc4;
    localparam logic [7:0] COTP_OFS_BANK1 = 8'hc5;
    localparam logic [7:0] COTP_OFS_BANK2 = 8'hc6;
    localparam logic [7:0] COTP_OFS_PROG = 8'hc8;
    localparam logic [7:0] COTP_OFS_IRQ_STAT = 8'hcc;
    localparam logic [7:0] COTP_OFS_IRQ_CLR = 8'hd0;
    localparam logic [7:0] COTP_OFS_IRQ_EN = 8'hd4;
    localparam logic [7:0] COTP_OFS_EVENT = 8'hd8;
    // Unprogrammed fuses read as zero
    localparam logic [7:0] COTP_BANK_RST = 8'h00;
    // Bank 0 fields
    localparam int COTP_B0_TOUCH_FN = 7;
    localparam int COTP_B0_PROX_FN = 6;
    localparam int COTP_B0_POL = 5;
    localparam int COTP_B0_TLVL_LO = 2;
    localparam int COTP_B0_PLVL_LO = 0;
    // Bank 1 fields
    localparam int COTP_B1_HALT_LO = 6;
    localparam int COTP_B1_BASE_LO = 0;
    // Bank 2 fields
    localparam int COTP_B2_STREAM = 7;
    localparam int COTP_B2_RATE = 6;
    localparam int COTP_B2_STREAM_EN = 5;
    localparam int COTP_B2_TARGET = 3;
    localparam int COTP_B2_PWR_LO = 0;
    // Interrupt status bits
    localparam int COTP_IRQ_TOUCH = 0;
    localparam int COTP_IRQ_PROX = 1;
    localparam int COTP_IRQ_REJECT = 2;
    // Timing
    localparam int COTP_CLK_MHZ = 250;
    localparam int COTP_LATCH_S = 4;
    localparam longint COTP_LATCH_CYC = longint'(COTP_LATCH_S) * 1000000
        * COTP_CLK_MHZ;
endpackage : cotp_pkg

/* src/cotp_config_decoder.sv */
// Operation
// - Each bank programmable once, then locked
// - Unprogrammed banks give zero defaults
// - Three banks at 0xc4, 0xc5, 0xc6
// - Bank0 bit7 touch: normal or toggle
// - Bank0 bit6 prox: normal or latch
// - Bank0 bit5 output polarity, push-pull
// - Bank0 bits4-2 touch threshold fraction
// - Bank0 bits1-0 prox threshold counts
// - Bank1 bits2-0 tuning base value
// - Bank2 bit7 streaming method
// - Bank2 bit6 charge pulse rate
// - Bank2 bit3 tuning target counts
// - Direct mode follows event
// - Latch holds four seconds, restartable
// - Toggle inverts at each event start
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ns
module cotp_config_decoder
    import cotp_pkg::*;
#(
    parameter longint LATCH_CYC = COTP_LATCH_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Raw events from the sensing core (same clock)
    input wire logic touch_event_i,
    input wire logic prox_event_i,
    // Event pins, push-pull
    output logic touch_event_out_o,
    output logic prox_event_out_o,
    // Decoded settings
    output logic [7:0] touch_level_sel_o,
    output logic [4:0] prox_level_sel_o,
    output logic [1:0] stuck_event_timeout_sel_o,
    output logic [8:0] tuning_base_o,
    output logic stream_i2c_o,
    output logic charge_pulse_rate_sel_o,
    output logic [10:0] auto_tuning_target_o,
    output logic stream_output_enable_o,
    output logic [1:0] power_mode_select_o,
    // Interrupt
    output logic irq_o
);
    typedef enum logic [1:0] {
        COTP_PWR_BOOST,
        COTP_PWR_NORMAL,
        COTP_PWR_LOW_ONE,
        COTP_PWR_LOW_TWO
    } cotp_pwr_e;

    logic [7:0] bank_q [3];
    logic [2:0] prog_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_en_q;
    logic wr_q;
    logic rd_q;
    logic [7:0] addr_q;
    logic touch_q;
    logic prox_q;
    logic touch_lvl_q;
    logic prox_lvl_q;
    logic [31:0] latch_cnt_q;
    logic [2:0] irq_set;
    logic [1:0] wr_bank;
    logic wr_bank_hit;
    logic touch_rise;
    logic prox_rise;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] b2;
    logic pol;

    assign b0 = bank_q[0];
    assign b1 = bank_q[1];
    assign b2 = bank_q[2];
    assign pol = b0[COTP_B0_POL];
    assign touch_rise = touch_event_i & ~touch_q;
    assign prox_rise = prox_event_i & ~prox_q;

    // Address phase capture; zero wait states, always OKAY
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (hready_i) begin
            wr_q <= hsel_i & htrans_i[1] & hwrite_i;
            rd_q <= hsel_i & htrans_i[1] & ~hwrite_i;
            // Word index; byte lanes are ignored, whole words only
            addr_q <= haddr_i[9:2];
        end
    end

    // Response stays ready; no wait states needed
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // Which bank a data phase targets
    always_comb begin
        wr_bank = 2'h0;
        wr_bank_hit = 1'b1;
        case (addr_q)
            COTP_OFS_BANK0: wr_bank = 2'h0;
            COTP_OFS_BANK1: wr_bank = 2'h1;
            COTP_OFS_BANK2: wr_bank = 2'h2;
            default: wr_bank_hit = 1'b0;
        endcase
    end

    // Fuse banks: a write lands only while the bank is still blank
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < 3; i++) begin
                bank_q[i] <= COTP_BANK_RST;
            end
            prog_q <= 3'h0;
        end else if (wr_q && wr_bank_hit && !prog_q[wr_bank]) begin
            bank_q[wr_bank] <= hwdata_i[7:0];
            prog_q[wr_bank] <= 1'b1;
        end
    end

    // Sticky status; set wins over clear in the same cycle
    always_comb begin
        irq_set = 3'h0;
        irq_set[COTP_IRQ_TOUCH] = touch_rise;
        irq_set[COTP_IRQ_PROX] = prox_rise;
        irq_set[COTP_IRQ_REJECT] = wr_q & wr_bank_hit & prog_q[wr_bank];
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_stat_q <= 3'h0;
            irq_en_q <= 3'h0;
        end else begin
            if (wr_q && addr_q == COTP_OFS_IRQ_EN) begin
                irq_en_q <= hwdata_i[2:0];
            end
            if (wr_q && addr_q == COTP_OFS_IRQ_CLR) begin
                irq_stat_q <= (irq_stat_q & ~hwdata_i[2:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_q & irq_en_q);
        end
    end

    // Read data mux; unmapped offsets read zero
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            hrdata_o <= 32'h0000_0000;
        end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
            case (haddr_i[9:2])
                COTP_OFS_BANK0: hrdata_o <= {24'h000000, b0};
                COTP_OFS_BANK1: hrdata_o <= {24'h000000, b1};
                COTP_OFS_BANK2: hrdata_o <= {24'h000000, b2};
                COTP_OFS_PROG: hrdata_o <= {29'h0, prog_q};
                COTP_OFS_IRQ_STAT: hrdata_o <= {29'h0, irq_stat_q};
                COTP_OFS_IRQ_EN: hrdata_o <= {29'h0, irq_en_q};
                COTP_OFS_EVENT: hrdata_o <= {28'h0, prox_lvl_q,
                    touch_lvl_q, prox_event_i, touch_event_i};
                default: hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // Event history for edge detection
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            touch_q <= 1'b0;
            prox_q <= 1'b0;
        end else begin
            touch_q <= touch_event_i;
            prox_q <= prox_event_i;
        end
    end

    // Touch logical level: follow or toggle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            touch_lvl_q <= 1'b0;
        end else if (b0[COTP_B0_TOUCH_FN]) begin
            if (touch_rise) begin
                touch_lvl_q <= ~touch_lvl_q;
            end
        end else begin
            touch_lvl_q <= touch_event_i;
        end
    end

    // Prox latch timer; a fresh event restarts the hold
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latch_cnt_q <= 32'h0000_0000;
        end else if (prox_rise) begin
            latch_cnt_q <= 32'(LATCH_CYC);
        end else if (latch_cnt_q != 32'h0000_0000) begin
            latch_cnt_q <= latch_cnt_q - 32'h0000_0001;
        end
    end

    // Prox logical level: follow, or held by the latch timer
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            prox_lvl_q <= 1'b0;
        end else if (b0[COTP_B0_PROX_FN]) begin
            prox_lvl_q <= prox_event_i | prox_rise
                | (latch_cnt_q > 32'h0000_0001);
        end else begin
            prox_lvl_q <= prox_event_i;
        end
    end

    // Pins: polarity applied last, driven both ways
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            touch_event_out_o <= 1'b1;
            prox_event_out_o <= 1'b1;
        end else begin
            touch_event_out_o <= touch_lvl_q ~^ pol;
            prox_event_out_o <= prox_lvl_q ~^ pol;
        end
    end

    // Decode settings into ready-to-use values
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            touch_level_sel_o <= 8'h48;
            prox_level_sel_o <= 5'h04;
            stuck_event_timeout_sel_o <= 2'h0;
            tuning_base_o <= 9'h0c8;
            stream_i2c_o <= 1'b0;
            charge_pulse_rate_sel_o <= 1'b0;
            auto_tuning_target_o <= 11'h400;
            stream_output_enable_o <= 1'b0;
            power_mode_select_o <= 2'(COTP_PWR_BOOST);
        end else begin
            case (b0[COTP_B0_TLVL_LO +: 3])
                3'h0: touch_level_sel_o <= 8'h48;
                3'h1: touch_level_sel_o <= 8'h08;
                3'h2: touch_level_sel_o <= 8'h18;
                3'h3: touch_level_sel_o <= 8'h30;
                3'h4: touch_level_sel_o <= 8'h60;
                3'h5: touch_level_sel_o <= 8'h80;
                3'h6: touch_level_sel_o <= 8'ha0;
                default: touch_level_sel_o <= 8'hc0;
            endcase
            case (b0[COTP_B0_PLVL_LO +: 2])
                2'h0: prox_level_sel_o <= 5'h04;
                2'h1: prox_level_sel_o <= 5'h02;
                2'h2: prox_level_sel_o <= 5'h08;
                default: prox_level_sel_o <= 5'h10;
            endcase
            // 0:20s 1:40s 2:never 3:always, prox at 40s
            stuck_event_timeout_sel_o <= b1[COTP_B1_HALT_LO +: 2];
            case (b1[COTP_B1_BASE_LO +: 3])
                3'h0: tuning_base_o <= 9'h0c8;
                3'h1: tuning_base_o <= 9'h032;
                3'h2: tuning_base_o <= 9'h04b;
                3'h3: tuning_base_o <= 9'h064;
                3'h4: tuning_base_o <= 9'h096;
                3'h5: tuning_base_o <= 9'h0fa;
                3'h6: tuning_base_o <= 9'h12c;
                default: tuning_base_o <= 9'h1f4;
            endcase
            stream_i2c_o <= b2[COTP_B2_STREAM];
            charge_pulse_rate_sel_o <= b2[COTP_B2_RATE];
            auto_tuning_target_o <= b2[COTP_B2_TARGET] ? 11'h200
                : 11'h400;
            stream_output_enable_o <= b2[COTP_B2_STREAM_EN];
            power_mode_select_o <= b2[COTP_B2_PWR_LO +: 2];
        end
    end
endmodule : cotp_config_decoder

/* tb/cotp_config_decoder_monitor.sv */
`timescale 1ns/1ns
module cotp_monitor (
    // Clock, reset and bus
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    // Events, pins and settings
    input wire logic touch_event_i,
    input wire logic touch_event_out_o,
    input wire logic prox_event_out_o,
    input wire logic [7:0] touch_level_sel_o,
    input wire logic [4:0] prox_level_sel_o,
    input wire logic [8:0] tuning_base_o,
    input wire logic charge_pulse_rate_sel_o,
    input wire logic [10:0] auto_tuning_target_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Write address phase taken by the slave
    wire wr = hsel_i && hready_i && htrans_i[1] && hwrite_i;
    // Zero wait states, always OKAY
    property p_rdy; hreadyout_o && !hresp_o; endproperty
    a_rdy: assert property (p_rdy) else $error("bus stalled");
    // Decoded fields only ever hold table values
    property p_tlvl;
        touch_level_sel_o inside {8'h48, 8'h08, 8'h18, 8'h30,
            8'h60, 8'h80, 8'ha0, 8'hc0};
    endproperty
    a_tlvl: assert property (p_tlvl) else $error("bad touch level");
    property p_plvl;
        prox_level_sel_o inside {5'h02, 5'h04, 5'h08, 5'h10};
    endproperty
    a_plvl: assert property (p_plvl) else $error("bad prox level");
    property p_base;
        tuning_base_o inside {9'h0c8, 9'h032, 9'h04b, 9'h064,
            9'h096, 9'h0fa, 9'h12c, 9'h1f4};
    endproperty
    a_base: assert property (p_base) else $error("bad base");
    property p_tgt; auto_tuning_target_o inside {11'h400, 11'h200};
    endproperty
    a_tgt: assert property (p_tgt) else $error("bad target");
    // A bank is written once, so a setting never moves twice in a row
    property p_lock;
        $changed(tuning_base_o) |=> $stable(tuning_base_o) [*8];
    endproperty
    a_lock: assert property (p_lock) else $error("base moved");
    // Settings move only as a result of a bus write
    property p_cfg;
        $changed(charge_pulse_rate_sel_o) |->
            $past(wr, 2) || $past(wr, 3) || $past(wr, 4);
    endproperty
    a_cfg: assert property (p_cfg) else $error("rate moved");
    // Touch pin moves only after a touch edge or a polarity write
    property p_tpin;
        $changed(touch_event_out_o) |->
            $past(touch_event_i) != $past(touch_event_i, 2) ||
            $past(touch_event_i, 2) != $past(touch_event_i, 3) ||
            $past(wr, 3) || $past(wr, 4) || $past(wr, 5);
    endproperty
    a_tpin: assert property (p_tpin) else $error("touch pin moved");
    // Main scenarios reached
    c_irq: cover property ($rose(irq_o));
    c_prox: cover property ($changed(prox_event_out_o));
    c_lvl: cover property ($changed(touch_level_sel_o));
endmodule : cotp_monitor

/* tb/cotp_host_model.sv */
`timescale 1ns/1ns
module cotp_host_model (
    // Clock, pins and chosen polarity
    input wire logic clk_i,
    input wire logic touch_pin_i,
    input wire logic prox_pin_i,
    input wire logic act_high_i,
    // Activity as the host reads it
    output logic touch_act_o,
    output logic prox_act_o
);
    // One input flop, as a real host port would sample
    always_ff @(posedge clk_i) begin
        touch_act_o <= touch_pin_i == act_high_i;
        prox_act_o <= prox_pin_i == act_high_i;
    end
endmodule : cotp_host_model

/* tb/test_capsense_otp_config_decoder.sv */
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
    $display("ERROR %s exp %0h got %0h", n, e, s); end end
module test_capsense_otp_config_decoder;
    // Short latch keeps the run brief
    localparam int LC = 20;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, hsel_i = 1'b1, hwrite_i = 1'b0;
    logic touch_event_i = 1'b0, prox_event_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
    logic hreadyout_o, hresp_o, touch_event_out_o, prox_event_out_o, irq_o;
    logic stream_i2c_o, charge_pulse_rate_sel_o, stream_output_enable_o;
    logic [1:0] stuck_event_timeout_sel_o, power_mode_select_o;
    logic [7:0] touch_level_sel_o;
    logic [4:0] prox_level_sel_o;
    logic [8:0] tuning_base_o;
    logic [10:0] auto_tuning_target_o;
    logic ta_h, pa_h, ta, pa;
    logic [7:0] b[3];
    int errors = 0, checks = 0, cyc = 0;
    int tl[8] = '{8'h48, 8'h08, 8'h18, 8'h30, 8'h60, 8'h80, 8'ha0, 8'hc0};
    int pl[4] = '{8'h04, 8'h02, 8'h08, 8'h10};
    int bs[8] = '{9'h0c8, 9'h032, 9'h04b, 9'h064, 9'h096, 9'h0fa, 9'h12c,
        9'h1f4};
    // Single slave, so its ready is the bus ready
    wire hready_i = hreadyout_o;
    wire logic [4:0] b2_dec = {stream_i2c_o, charge_pulse_rate_sel_o,
        stream_output_enable_o, power_mode_select_o};
    cotp_config_decoder #(.LATCH_CYC(LC)) dut (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .hsel_i(hsel_i),
        .haddr_i(haddr_i),
        .htrans_i(htrans_i),
        .hwrite_i(hwrite_i),
        .hsize_i(hsize_i),
        .hwdata_i(hwdata_i),
        .hready_i(hready_i),
        .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o),
        .touch_event_i(touch_event_i),
        .prox_event_i(prox_event_i),
        .touch_event_out_o(touch_event_out_o),
        .prox_event_out_o(prox_event_out_o),
        .touch_level_sel_o(touch_level_sel_o),
        .prox_level_sel_o(prox_level_sel_o),
        .stuck_event_timeout_sel_o(stuck_event_timeout_sel_o),
        .tuning_base_o(tuning_base_o),
        .stream_i2c_o(stream_i2c_o),
        .charge_pulse_rate_sel_o(charge_pulse_rate_sel_o),
        .auto_tuning_target_o(auto_tuning_target_o),
        .stream_output_enable_o(stream_output_enable_o),
        .power_mode_select_o(power_mode_select_o),
        .irq_o(irq_o)
    );
    cotp_host_model host (
        .clk_i(clk_i),
        .touch_pin_i(touch_event_out_o),
        .prox_pin_i(prox_event_out_o),
        .act_high_i(b[0][5]),
        .touch_act_o(ta_h),
        .prox_act_o(pa_h)
    );
    always #2 clk_i = ~clk_i;
    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc > 5000) begin
            errors++;
            end_of_test();
        end
    end
    // One single AHB transfer to word index a, waits on ready in both phases
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        htrans_i <= 2'h2;
        hwrite_i <= w;
        haddr_i <= {22'h0, a, 2'h0};
        @(posedge clk_i);
        while (!hreadyout_o) @(posedge clk_i);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clk_i);
        while (!hreadyout_o) @(posedge clk_i);
        r = hrdata_o;
    endtask : xfer
    // Reset also blanks the fuse banks
    task automatic rst;
        sys_rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        b = '{8'h00, 8'h00, 8'h00};
        ta = 1'b0;
        pa = 1'b0;
        @(posedge clk_i);
    endtask : rst
    // Banks read back and decoded against the model
    task automatic chk_cfg;
        for (int k = 0; k < 3; k++) begin
            xfer(1'b0, 8'hc4 + 8'(k), 32'h0, rd);
            `CHK("bank", {24'h0, b[k]}, rd)
        end
        `CHK("tlvl", tl[b[0][4:2]], touch_level_sel_o)
        `CHK("plvl", pl[b[0][1:0]], prox_level_sel_o)
        `CHK("halt", b[1][7:6], stuck_event_timeout_sel_o)
        `CHK("base", bs[b[1][2:0]], tuning_base_o)
        `CHK("b2", {b[2][7:5], b[2][1:0]}, b2_dec)
        `CHK("tgt", b[2][3] ? 512 : 1024, auto_tuning_target_o)
    endtask : chk_cfg
    // One event pulse, looked at by the host during and after it
    task automatic ev(input logic t);
        touch_event_i <= t;
        prox_event_i <= !t;
        if (t)
            ta = b[0][7] ? !ta : 1'b1;
        else
            pa = 1'b1;
        repeat (4) @(posedge clk_i);
        `CHK("act", {ta, pa}, {ta_h, pa_h})
        touch_event_i <= 1'b0;
        prox_event_i <= 1'b0;
        ta = ta & b[0][7];
        pa = pa & b[0][6];
        repeat (4) @(posedge clk_i);
        `CHK("hold", {ta, pa}, {ta_h, pa_h})
        repeat (LC) @(posedge clk_i);
        pa = 1'b0;
        `CHK("end", {ta, pa}, {ta_h, pa_h})
    endtask : ev
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    // Every bank 0 and bank 1 field code, power mode and output mode, one blank device each pass
    initial begin
        void'($urandom(74));
        for (int i = 0; i < 8; i++) begin
            rst();
            chk_cfg();
            b[0] = {i[2:0], i[2:0], i[1:0]};
            b[1] = 8'($urandom);
            b[1][7:6] = i[1:0];
            b[1][2:0] = i[2:0];
            b[2] = 8'($urandom);
            b[2][1:0] = i[1:0];
            // First writes take, rewrites with other values are refused
            for (int k = 0; k < 6; k++)
                xfer(1'b1, 8'hc4 + 8'(k % 3),
                    {24'($urandom), k < 3 ? b[k % 3] : ~b[k % 3]}, rd);
            chk_cfg();
            xfer(1'b0, 8'hc8, 32'h0, rd);
            `CHK("locks", 32'h7, rd)
            xfer(1'b1, 8'hd4, 32'h1, rd);
            ev(1'b0);
            `CHK("irq masked", 1'b0, irq_o)
            ev(1'b1);
            `CHK("irq", 1'b1, irq_o)
            ev(1'b1);
            xfer(1'b0, 8'hcc, 32'h0, rd);
            `CHK("status", 32'h7, rd)
            xfer(1'b1, 8'hd0, 32'h7, rd);
            xfer(1'b0, 8'hcc, 32'h0, rd);
            `CHK("cleared", 32'h0, rd)
            `CHK("irq off", 1'b0, irq_o)
            xfer(1'b0, 8'hd8, 32'h0, rd);
            `CHK("state", {29'h0, ta, 2'h0}, rd)
            xfer(1'b0, 8'hf0, 32'h0, rd);
            `CHK("unmapped", 32'h0, rd)
        end
        end_of_test();
    end
endmodule : test_capsense_otp_config_decoder
bind cotp_config_decoder cotp_monitor mon (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .hsel_i(hsel_i),
    .htrans_i(htrans_i),
    .hwrite_i(hwrite_i),
    .hready_i(hready_i),
    .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o),
    .touch_event_i(touch_event_i),
    .touch_event_out_o(touch_event_out_o),
    .prox_event_out_o(prox_event_out_o),
    .touch_level_sel_o(touch_level_sel_o),
    .prox_level_sel_o(prox_level_sel_o),
    .tuning_base_o(tuning_base_o),
    .charge_pulse_rate_sel_o(charge_pulse_rate_sel_o),
    .auto_tuning_target_o(auto_tuning_target_o),
    .irq_o(irq_o)
);
